/* core/dcd_map.vh */
`ifndef DCD_MAP_VH
`define DCD_MAP_VH
`define DCD_SERVICE_TYPE 8'h02
`define DCD_SUB_PULSE 8'h01
`define DCD_SUB_REGLOAD 8'h02
`define DCD_SUB_LINE 8'h03
`define DCD_MAX_DURATION 8'h08
`define DCD_CLK_MHZ 200
`define DCD_TIME_BASE_MS 10
`define DCD_TIME_BASE_CYCLES (`DCD_TIME_BASE_MS * 1000 * `DCD_CLK_MHZ)
`define DCD_LEN_W 4
`endif

/* core/dcd_pulse_timer.v */
`timescale 1ns/10ps
module dcd_pulse_timer #(
    parameter BASE_CYCLES = 2000000
) (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // command
    input wire start_i,
    input wire [3:0] code_i,
    // status
    output reg busy_o
);
    reg [31:0] base_cnt_reg;
    reg [8:0] unit_cnt_reg;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            base_cnt_reg <= 32'h0;
            unit_cnt_reg <= 9'h0;
            busy_o <= 1'b0;
        end else if (start_i) begin
            // length is base times two to the code
            base_cnt_reg <= BASE_CYCLES - 1;
            unit_cnt_reg <= (9'h1 << code_i) - 9'h1;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            if (base_cnt_reg != 32'h0) begin
                base_cnt_reg <= base_cnt_reg - 32'h1;
            end else if (unit_cnt_reg != 9'h0) begin
                base_cnt_reg <= BASE_CYCLES - 1;
                unit_cnt_reg <= unit_cnt_reg - 9'h1;
            end else begin
                busy_o <= 1'b0;
            end
        end
    end
endmodule

/* core/dcd_distributor.v */
`timescale 1ns/10ps
`include "dcd_map.vh"
module dcd_distributor #(
    parameter TIME_BASE_CYCLES = `DCD_TIME_BASE_CYCLES,
    parameter MAX_LINE_INSTR = 16,
    parameter LINE_COUNT = 8
) (
    // clock and reset
    input wire CLK_I,
    input wire RESETN_I,
    // packet octet stream
    input wire PKT_START_I,
    input wire [7:0] PKT_TYPE_I,
    input wire [7:0] PKT_SUBTYPE_I,
    input wire OCTET_VALID_I,
    input wire [7:0] OCTET_I,
    input wire PKT_END_I,
    output reg OCTET_READY_O,
    // pulse commands
    output reg CHAN_PULSE_O,
    output reg [7:0] CHAN_ADDR_O,
    // register loads
    output reg REG_WR_O,
    output reg [7:0] REG_ADDR_O,
    output reg [7:0] REG_DATA_O,
    output reg REG_LAST_O,
    // line pulses
    output reg [LINE_COUNT-1:0] PULSE_LINE_O,
    // status
    output reg REJECT_O
);
    localparam S_IDLE = 3'h0;
    localparam S_COUNT = 3'h1;
    localparam S_CHAN = 3'h2;
    localparam S_RADDR = 3'h3;
    localparam S_RDATA = 3'h4;
    localparam S_LSEL = 3'h5;
    localparam S_LDUR = 3'h6;
    localparam S_LRUN = 3'h7;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] sub_reg;
    reg [7:0] sub_next;
    reg [7:0] items_reg;
    reg [7:0] items_next;
    reg [3:0] len_reg;
    reg [3:0] len_next;
    reg [7:0] sel_reg;
    reg [7:0] sel_next;
    reg [3:0] code_reg;
    reg [3:0] code_next;
    reg [7:0] ninstr_reg;
    reg [7:0] ninstr_next;
    reg timer_start_reg;
    reg timer_start_next;
    reg end_seen_reg;
    reg end_seen_next;
    reg ready_next;
    reg chan_pulse_next;
    reg [7:0] chan_addr_next;
    reg reg_wr_next;
    reg [7:0] reg_addr_next;
    reg [7:0] reg_data_next;
    reg reg_last_next;
    reg [LINE_COUNT-1:0] line_next;
    reg reject_next;
    wire timer_busy;

    // data length in octets implied by the register address; top two bits pick it
    function [3:0] data_len;
        input [7:0] addr;
        begin
            data_len = (addr[7:6] == 2'h0) ? 4'h1 : {2'h0, addr[7:6]} + 4'h1;
        end
    endfunction

    // one item of the packet's count consumed
    function [7:0] one_less;
        input [7:0] n;
        begin
            one_less = n - 8'h1;
        end
    endfunction

    dcd_pulse_timer #(
        .BASE_CYCLES(TIME_BASE_CYCLES)
    ) u_timer (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .start_i(timer_start_reg),
        .code_i(code_reg),
        .busy_o(timer_busy)
    );

    // no reply path exists at all; nothing here builds telemetry
    always @* begin
        state_next = state_reg;
        sub_next = sub_reg;
        items_next = items_reg;
        len_next = len_reg;
        sel_next = sel_reg;
        code_next = code_reg;
        ninstr_next = ninstr_reg;
        timer_start_next = 1'b0;
        end_seen_next = end_seen_reg;
        ready_next = OCTET_READY_O;
        chan_pulse_next = 1'b0;
        chan_addr_next = CHAN_ADDR_O;
        reg_wr_next = 1'b0;
        reg_addr_next = REG_ADDR_O;
        reg_data_next = REG_DATA_O;
        reg_last_next = 1'b0;
        line_next = PULSE_LINE_O;
        reject_next = 1'b0;
        case (state_reg)
            S_IDLE: begin
                ready_next = 1'b0;
                ninstr_next = 8'h0;
                end_seen_next = 1'b0;
                if (PKT_START_I) begin
                    sub_next = PKT_SUBTYPE_I;
                    ready_next = 1'b1;
                    if (PKT_TYPE_I != `DCD_SERVICE_TYPE) begin
                        ready_next = 1'b0;
                    end else if (PKT_SUBTYPE_I == `DCD_SUB_LINE) begin
                        state_next = S_LSEL;
                    end else if (PKT_SUBTYPE_I == `DCD_SUB_PULSE ||
                                 PKT_SUBTYPE_I == `DCD_SUB_REGLOAD) begin
                        state_next = S_COUNT;
                    end else begin
                        ready_next = 1'b0;
                        reject_next = 1'b1;
                    end
                end
            end

            S_COUNT: begin
                if (OCTET_VALID_I) begin
                    items_next = OCTET_I;
                    if (OCTET_I == 8'h0) begin
                        reject_next = 1'b1;
                        ready_next = 1'b0;
                        state_next = S_IDLE;
                    end else if (sub_reg == `DCD_SUB_PULSE) begin
                        state_next = S_CHAN;
                    end else begin
                        state_next = S_RADDR;
                    end
                end
            end

            S_CHAN: begin
                if (OCTET_VALID_I) begin
                    chan_pulse_next = 1'b1;
                    chan_addr_next = OCTET_I;
                    items_next = one_less(items_reg);
                    if (items_reg == 8'h1) begin
                        ready_next = 1'b0;
                        state_next = S_IDLE;
                    end
                end
            end

            S_RADDR: begin
                if (OCTET_VALID_I) begin
                    reg_addr_next = OCTET_I;
                    len_next = data_len(OCTET_I);
                    state_next = S_RDATA;
                end
            end

            S_RDATA: begin
                if (OCTET_VALID_I) begin
                    reg_wr_next = 1'b1;
                    reg_data_next = OCTET_I;
                    len_next = len_reg - 4'h1;
                    if (len_reg == 4'h1) begin
                        reg_last_next = 1'b1;
                        items_next = one_less(items_reg);
                        if (items_reg == 8'h1) begin
                            ready_next = 1'b0;
                            state_next = S_IDLE;
                        end else begin
                            state_next = S_RADDR;
                        end
                    end
                end
            end

            S_LSEL: begin
                if (PKT_END_I) begin
                    ready_next = 1'b0;
                    state_next = S_IDLE;
                end else if (OCTET_VALID_I) begin
                    sel_next = OCTET_I;
                    state_next = S_LDUR;
                end
            end

            S_LDUR: begin
                if (OCTET_VALID_I) begin
                    ready_next = 1'b0;
                    // a bad code aborts the rest of the packet
                    if (OCTET_I > `DCD_MAX_DURATION ||
                        ninstr_reg >= MAX_LINE_INSTR) begin
                        reject_next = 1'b1;
                        state_next = S_IDLE;
                    end else begin
                        // the code leaves the bus before the timer starts, so it is kept here
                        code_next = OCTET_I[3:0];
                        timer_start_next = 1'b1;
                        ninstr_next = ninstr_reg + 8'h1;
                        if (sel_reg < LINE_COUNT) begin
                            line_next[sel_reg[2:0]] = 1'b1;
                        end
                        state_next = S_LRUN;
                    end
                end
            end

            S_LRUN: begin
                // back-pressure holds the next instruction until the line drops
                if (PKT_END_I) begin
                    end_seen_next = 1'b1;
                end
                if (!timer_start_reg && !timer_busy) begin
                    line_next = {LINE_COUNT{1'b0}};
                    if (end_seen_reg || PKT_END_I) begin
                        state_next = S_IDLE;
                    end else begin
                        ready_next = 1'b1;
                        state_next = S_LSEL;
                    end
                end
            end

            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // every output is a flip-flop; the sequencer above only feeds them
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= S_IDLE;
            sub_reg <= 8'h0;
            items_reg <= 8'h0;
            len_reg <= 4'h0;
            sel_reg <= 8'h0;
            code_reg <= 4'h0;
            ninstr_reg <= 8'h0;
            timer_start_reg <= 1'b0;
            end_seen_reg <= 1'b0;
            OCTET_READY_O <= 1'b0;
            CHAN_PULSE_O <= 1'b0;
            CHAN_ADDR_O <= 8'h0;
            REG_WR_O <= 1'b0;
            REG_ADDR_O <= 8'h0;
            REG_DATA_O <= 8'h0;
            REG_LAST_O <= 1'b0;
            PULSE_LINE_O <= {LINE_COUNT{1'b0}};
            REJECT_O <= 1'b0;
        end else begin
            state_reg <= state_next;
            sub_reg <= sub_next;
            items_reg <= items_next;
            len_reg <= len_next;
            sel_reg <= sel_next;
            code_reg <= code_next;
            ninstr_reg <= ninstr_next;
            timer_start_reg <= timer_start_next;
            end_seen_reg <= end_seen_next;
            OCTET_READY_O <= ready_next;
            CHAN_PULSE_O <= chan_pulse_next;
            CHAN_ADDR_O <= chan_addr_next;
            REG_WR_O <= reg_wr_next;
            REG_ADDR_O <= reg_addr_next;
            REG_DATA_O <= reg_data_next;
            REG_LAST_O <= reg_last_next;
            PULSE_LINE_O <= line_next;
            REJECT_O <= reject_next;
        end
    end
endmodule

/* sim/dcd_distributor_sva.sv */
`timescale 1ns/10ps
module dcd_distributor_sva #(
    parameter TIME_BASE_CYCLES = 4,
    parameter LINE_COUNT = 8
) (
    // clock and reset
    input wire CLK_I,
    input wire RESETN_I,
    // packet stream
    input wire PKT_START_I,
    input wire [7:0] PKT_TYPE_I,
    input wire [7:0] PKT_SUBTYPE_I,
    input wire OCTET_VALID_I,
    input wire [7:0] OCTET_I,
    input wire OCTET_READY_O,
    // results
    input wire CHAN_PULSE_O,
    input wire REG_WR_O,
    input wire REG_LAST_O,
    input wire [LINE_COUNT-1:0] PULSE_LINE_O,
    input wire REJECT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire take = OCTET_VALID_I && OCTET_READY_O;
    wire good = PKT_START_I && PKT_TYPE_I == 8'h02 && PKT_SUBTYPE_I inside {[8'h01:8'h03]};
    reg [7:0] code_reg;
    reg [31:0] cnt_reg;
    // the code octet is the last one taken before a line rises; no octet is taken meanwhile
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            code_reg <= 8'h00;
            cnt_reg <= 32'h0;
        end else begin
            code_reg <= take ? OCTET_I : code_reg;
            cnt_reg <= (|PULSE_LINE_O) ? cnt_reg + 32'h1 : 32'h0;
        end
    end
    start_ready_a: assert property (good |=> OCTET_READY_O)
        else $error("ready missing after start");
    type_ignored_a: assert property (PKT_START_I && PKT_TYPE_I != 8'h02 && !OCTET_READY_O
        |=> (!OCTET_READY_O && !REJECT_O)[*3]) else $error("foreign type acted upon");
    chan_cause_a: assert property (CHAN_PULSE_O |-> $past(take) && !REG_WR_O && !REJECT_O)
        else $error("channel pulse without octet");
    reg_cause_a: assert property (REG_WR_O |-> $past(take))
        else $error("register write without octet");
    last_write_a: assert property (REG_LAST_O |-> REG_WR_O)
        else $error("last flag without write");
    line_width_a: assert property ($fell(|PULSE_LINE_O) |-> cnt_reg >= (TIME_BASE_CYCLES << code_reg)
        && cnt_reg <= (TIME_BASE_CYCLES << code_reg) + 4) else $error("line width wrong");
    line_single_a: assert property ((|PULSE_LINE_O) |-> $onehot(PULSE_LINE_O) && !OCTET_READY_O)
        else $error("line overlap");
    reject_stop_a: assert property (REJECT_O |=> !REJECT_O && !OCTET_READY_O)
        else $error("reject not one cycle or ready kept");
    cover property (CHAN_PULSE_O);
    cover property (REG_LAST_O);
    cover property ($fell(|PULSE_LINE_O));
    cover property (REJECT_O);
endmodule
bind dcd_distributor dcd_distributor_sva #(.TIME_BASE_CYCLES(TIME_BASE_CYCLES),
    .LINE_COUNT(LINE_COUNT)) u_sva (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PKT_START_I(PKT_START_I),
    .PKT_TYPE_I(PKT_TYPE_I), .PKT_SUBTYPE_I(PKT_SUBTYPE_I), .OCTET_VALID_I(OCTET_VALID_I),
    .OCTET_I(OCTET_I), .OCTET_READY_O(OCTET_READY_O), .CHAN_PULSE_O(CHAN_PULSE_O),
    .REG_WR_O(REG_WR_O), .REG_LAST_O(REG_LAST_O), .PULSE_LINE_O(PULSE_LINE_O), .REJECT_O(REJECT_O));

/* sim/dcd_source.sv */
`timescale 1ns/10ps
module dcd_source (
    // clock and handshake
    input wire clk_i,
    input wire ready_i,
    // packet stream
    output logic start_o,
    output logic [7:0] type_o,
    output logic [7:0] sub_o,
    output logic valid_o,
    output logic [7:0] octet_o,
    output logic end_o
);
    logic [7:0] q[$];
    initial begin
        {start_o, valid_o, end_o} = 3'h0;
        {type_o, sub_o, octet_o} = 24'hffffff;
    end
    // bounded, since a refused packet never raises ready again
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 1200) begin
            @(posedge clk_i);
            ok = (ready_i === 1'b1);
            n++;
        end
    endtask
    task automatic send(input logic [7:0] t, input logic [7:0] s, input logic fin);
        logic ok;
        @(negedge clk_i);
        start_o = 1'b1;
        type_o = t;
        sub_o = s;
        @(negedge clk_i);
        start_o = 1'b0;
        type_o = ~t;
        sub_o = ~s;
        while (q.size() > 0) begin
            valid_o = 1'b1;
            octet_o = q[0];
            wait_ready(ok);
            @(negedge clk_i);
            if (ok)
                void'(q.pop_front());
            else
                q = {};
            if (q.size() == 0) begin
                valid_o = 1'b0;
                octet_o = ~octet_o;
            end
        end
        if (fin) begin
            wait_ready(ok);
            @(negedge clk_i);
            end_o = 1'b1;
            @(negedge clk_i);
            end_o = 1'b0;
        end
    endtask
endmodule

/* sim/dcd_distributor_test.sv */
`timescale 1ns/10ps
module dcd_distributor_test;
    logic clk, resetn, start, valid, pend, ready, chan, wr, last, rej;
    logic [7:0] ptype, psub, octet, caddr, raddr, rdata, lines, line_v;
    int errors, check_count, rej_n, line_w;
    logic [7:0] chan_q[$], line_q[$];
    logic [16:0] wr_q[$];
    int width_q[$];
    dcd_distributor #(.TIME_BASE_CYCLES(4)) DUT (.CLK_I(clk), .RESETN_I(resetn),
        .PKT_START_I(start), .PKT_TYPE_I(ptype), .PKT_SUBTYPE_I(psub), .OCTET_VALID_I(valid),
        .OCTET_I(octet), .PKT_END_I(pend), .OCTET_READY_O(ready), .CHAN_PULSE_O(chan),
        .CHAN_ADDR_O(caddr), .REG_WR_O(wr), .REG_ADDR_O(raddr), .REG_DATA_O(rdata),
        .REG_LAST_O(last), .PULSE_LINE_O(lines), .REJECT_O(rej));
    dcd_source src (.clk_i(clk), .ready_i(ready), .start_o(start), .type_o(ptype), .sub_o(psub),
        .valid_o(valid), .octet_o(octet), .end_o(pend));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (chan === 1'b1) chan_q.push_back(caddr);
        if (wr === 1'b1) wr_q.push_back({raddr, rdata, last});
        if (rej === 1'b1) rej_n++;
        if (|lines) begin
            line_w++;
            line_v = lines;
        end else if (line_w > 0) begin
            line_q.push_back(line_v);
            width_q.push_back(line_w);
            line_w = 0;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task t_pulse;
        src.q = '{8'h02, 8'h11, 8'h22};
        src.send(8'h02, 8'h01, 1'b0);
        repeat (4) @(negedge clk);
        check(chan_q.size(), 2);
        check({chan_q[0], chan_q[1]}, 16'h1122);
    endtask
    task t_reg;
        src.q = '{8'h02, 8'h05, 8'ha5, 8'h41, 8'h12, 8'h34};
        src.send(8'h02, 8'h02, 1'b0);
        repeat (4) @(negedge clk);
        check(wr_q.size(), 3);
        check(wr_q[0][16:1], 16'h05a5);
        check(wr_q[1], {16'h4112, 1'b0});
        check(wr_q[2], {16'h4134, 1'b1});
    endtask
    // one instruction past the limit rejects the rest of the packet
    task automatic t_limit;
        rej_n = 0;
        src.q = {};
        for (int i = 0; i < 17; i++) begin
            src.q.push_back(8'h01);
            src.q.push_back(8'h00);
        end
        src.send(8'h02, 8'h03, 1'b0);
        repeat (4) @(negedge clk);
        check(line_q.size(), 16);
        check(rej_n, 1);
    endtask
    // line 0 with code 8 is the longest pulse the sender may ask for
    task automatic t_line;
        int sel[3] = '{3, 5, 0};
        int cd[3] = '{0, 2, 8};
        src.q = '{8'h03, 8'h00, 8'h05, 8'h02, 8'h00, 8'h08};
        src.send(8'h02, 8'h03, 1'b1);
        repeat (4) @(negedge clk);
        check(line_q.size(), 3);
        for (int i = 0; i < 3; i++) begin
            check(line_q[i], 8'h01 << sel[i]);
            check(width_q[i] >= (4 << cd[i]) && width_q[i] <= (4 << cd[i]) + 4, 1);
        end
    endtask
    task automatic t_reject;
        logic [7:0] sub[3] = '{8'h01, 8'h04, 8'h03};
        logic [7:0] b0[3] = '{8'h00, 8'h01, 8'h01};
        logic [7:0] b1[3] = '{8'h33, 8'h33, 8'h09};
        for (int i = 0; i < 3; i++) begin
            rej_n = 0;
            src.q = '{b0[i], b1[i]};
            src.send(8'h02, sub[i], 1'b0);
            repeat (4) @(negedge clk);
            check(rej_n, 1);
        end
        check(chan_q.size() + line_q.size(), 0);
    endtask
    task t_type;
        rej_n = 0;
        src.q = '{8'h01, 8'h44};
        src.send(8'h05, 8'h01, 1'b0);
        check(rej_n + chan_q.size(), 0);
    endtask
    task clear_q;
        chan_q = {};
        wr_q = {};
        line_q = {};
        width_q = {};
    endtask
    initial begin
        resetn = 1'b0;
        {errors, check_count, rej_n, line_w} = 0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        t_pulse;
        clear_q;
        t_reg;
        clear_q;
        t_line;
        clear_q;
        t_reject;
        clear_q;
        t_limit;
        t_type;
        end_sim;
    end
    initial begin
        #150000;
        errors++;
        end_sim;
    end
endmodule
